/* File: hdl/ffehp_pkg.sv */
// Purpose: Constants for the FIR front end and host port
// Assumes: One 25 MHz clock, synchronous active-high reset
// Notes:   Field layouts inside the control words are local choices
//
// Overview of operation
// - Thirteen control words at addresses 0..12
// - Coefficients at 128..255, four per cell
// - Snapshot words at addresses 256..511
// - Write to 11 gives one-cycle low pulse
// - Register follows bus while write and enable low
// - Bus driven only on enabled read, else released
// - Read strobe tied low gives read/write style
// - Counter counts 16*value+15 down to zero
// - Low terminal-count strobe at each zero
// - Sync input reloads counter unless sync disabled
// - Counter LSBs sequence logic, 12 LSBs diagnostic
// - Sync output picks delayed sync, pulse, terminal
// - Each path selects port A, B or counter
// - Input stage optionally holds two or four clocks
// - Input delay of zero, one or three clocks
// - Negate none, all, even or odd samples
// - Sixteen cells plus symmetric feedback stage
// - Coefficient select fixed, toggled or rotated
// - Cascade joins both paths into one chain
// - Pipeline stages add only latency
// - Twelve-bit samples, fourteen-bit coefficients

package ffehp_pkg;
  localparam int AW        = 9;
  localparam int DW        = 16;
  localparam int SW        = 12;
  localparam int CW        = 14;
  localparam int NCELL     = 16;
  localparam int NCTRL     = 13;
  localparam int CNTW      = 20;
  localparam int NCOEF     = 128;
  localparam int NSNAP     = 256;
  localparam int FIFO_DEP  = 16;
  localparam int SI_DLY    = 4;
  localparam int PINW      = 28;
  // ----------------------------------------
  // Host addresses
  // ----------------------------------------
  localparam logic [AW-1:0] A_BPATH0  = 9'h002;
  localparam logic [AW-1:0] A_CASC    = 9'h004;
  localparam logic [AW-1:0] A_CNT     = 9'h005;
  localparam logic [AW-1:0] A_OUT     = 9'h006;
  localparam logic [AW-1:0] A_SNAPC   = 9'h009;
  localparam logic [AW-1:0] A_ONESHOT = 9'h00b;
  localparam logic [AW-1:0] A_LASTC   = 9'h00c;
  localparam logic [AW-1:0] A_COEF    = 9'h080;
  localparam logic [AW-1:0] A_SNAP    = 9'h100;
  // ----------------------------------------
  // Field positions in path and other control words
  // ----------------------------------------
  localparam int F_ISEL  = 0;
  localparam int F_HOLD  = 2;
  localparam int F_DLY   = 4;
  localparam int F_NEG   = 6;
  localparam int F_SYM   = 8;
  localparam int F_CSM   = 10;
  localparam int F_CSV   = 12;
  localparam int F_CASC  = 0;
  localparam int F_SSOFF = 0;
  localparam int F_SOSEL = 0;
  // ----------------------------------------
  // Two-bit mode codes and other constants
  // ----------------------------------------
  localparam logic [1:0] M_0 = 2'h0;
  localparam logic [1:0] M_1 = 2'h1;
  localparam logic [1:0] M_2 = 2'h2;
  localparam logic [1:0] M_3 = 2'h3;
  localparam logic [DW-1:0]   ZERO16   = 16'h0000;
  localparam logic [3:0]      CNT_LOW  = 4'hf;
  localparam logic [CNTW-1:0] CNT_ZERO = 20'h0_0000;
  localparam logic [CNTW-1:0] CNT_ONE  = 20'h0_0001;
endpackage

/* File: hdl/ffehp_fifo.sv */
// Purpose: Sample FIFO with valid/ready on both sides
// Assumes: Single clock
// Notes:   Output data is stale while empty
`timescale 1ns/1ps
module ffehp_fifo #(
  parameter int W = 24,
  parameter int D = 16
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int PW = $clog2(D);
  logic [W-1:0]  mem_r [D];
  logic [PW-1:0] wp_r;
  logic [PW-1:0] rp_r;
  logic [PW:0]   cnt_r;
  logic [PW:0]   cnt_nxt;
  logic          ready_r;
  logic          push_w;
  logic          pop_w;

  assign push_w    = in_valid & ready_r;
  assign pop_w     = out_ready & out_valid;
  assign in_ready  = ready_r;
  assign out_valid = cnt_r != '0;
  assign out_data  = mem_r[rp_r];
  assign cnt_nxt   = cnt_r + (PW+1)'(push_w) - (PW+1)'(pop_w);

  always_ff @(posedge clk) begin
    if (push_w) begin
      mem_r[wp_r] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wp_r   <= '0;
      rp_r   <= '0;
      cnt_r  <= '0;
      ready_r <= 1'b1;
    end else begin
      wp_r   <= wp_r + PW'(push_w);
      rp_r   <= rp_r + PW'(pop_w);
      cnt_r  <= cnt_nxt;
      // Kept as a flop so the ready pin needs no gate behind it
      ready_r <= cnt_nxt != (PW+1)'(D);
    end
  end
endmodule

/* File: hdl/ffehp_top.sv */
// Purpose: Host port, sync counter and two input/filter data paths
// Assumes: Host strobes and sync input are asynchronous pins
// Notes:   Cell arithmetic lives outside; chains carry data only
`timescale 1ns/1ps
module ffehp_top
  import ffehp_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          sys_rst,
  input  wire logic [AW-1:0] host_addr,
  input  wire logic [DW-1:0] host_data_in,
  output logic [DW-1:0]      host_data_out,
  output logic               host_data_oe_n,
  input  wire logic          chip_enable_n,
  input  wire logic          write_strobe_n,
  input  wire logic          read_strobe_n,
  input  wire logic          sync_in_n,
  output logic               sync_out_n,
  output logic               terminal_count_n,
  output logic               one_shot_pulse_n,
  output logic [2:0]         count_lsb_out,
  input  wire logic [SW-1:0] samp_a_in,
  input  wire logic [SW-1:0] samp_b_in,
  input  wire logic          samp_valid,
  output logic               samp_ready,
  input  wire logic [31:0]   sum_a_in,
  input  wire logic [31:0]   sum_b_in,
  output logic [31:0]        sum_a_out,
  output logic [31:0]        sum_b_out,
  output logic [SW-1:0]      data_a_out,
  output logic [SW-1:0]      data_b_out,
  output logic [SW-1:0]      fb_a_out,
  output logic [SW-1:0]      fb_b_out,
  output logic [1:0]         csel_a_out,
  output logic [1:0]         csel_b_out,
  output logic [CW-1:0]      coef_a_out,
  output logic [CW-1:0]      coef_b_out
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [PINW-1:0] p1_r;
  logic [PINW-1:0] p2_r;
  logic [PINW-1:0] p3_r;
  logic [2:0]      si_r;
  logic            si_lvl_r;
  logic [SI_DLY-1:0] si_d_r;
  logic            hst_ok;
  logic            ctl_ok;
  logic            h_ce_n;
  logic            h_we_n;
  logic            h_re_n;
  logic [AW-1:0]   h_addr;
  logic [DW-1:0]   h_data;
  logic            sync_ev;

  always_ff @(posedge clk) begin
    p1_r <= {chip_enable_n, write_strobe_n, read_strobe_n, host_addr, host_data_in};
    p2_r <= p1_r;
    p3_r <= p2_r;
    si_r <= {si_r[1:0], sync_in_n};
  end

  // A change counts only once stages two and three agree
  assign hst_ok = p2_r == p3_r;
  // Reads skip the data pins, which echo the word we drive
  assign ctl_ok = p2_r[PINW-1:DW] == p3_r[PINW-1:DW];
  assign {h_ce_n, h_we_n, h_re_n, h_addr, h_data} = p3_r;
  assign sync_ev = si_lvl_r & ~si_r[1] & ~si_r[2];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      si_lvl_r <= 1'b1;
      si_d_r   <= '1;
    end else begin
      if (si_r[1] == si_r[2]) begin
        si_lvl_r <= si_r[2];
      end
      si_d_r <= {si_d_r[SI_DLY-2:0], si_lvl_r};
    end
  end

  // ----------------------------------------
  // Host port decode
  // ----------------------------------------
  logic [DW-1:0] ctrl_r [NCTRL];
  logic [DW-1:0] coef_m [NCOEF];
  logic [DW-1:0] snap_m [NSNAP];
  logic          wr_act;
  logic          rd_act;
  logic          wr_prev_r;
  logic          is_ctrl;
  logic          is_coef;
  logic          is_snap;
  logic [DW-1:0] rd_w;

  // Same equations serve both strobe styles: a grounded read strobe
  // leaves write strobe high as read and low as write
  assign wr_act  = hst_ok & ~h_ce_n & ~h_we_n;
  assign rd_act  = ctl_ok & ~h_ce_n & ~h_re_n & h_we_n;
  assign is_ctrl = h_addr <= A_LASTC;
  assign is_coef = h_addr[8:7] == 2'b01;
  assign is_snap = h_addr[8];
  assign rd_w = is_snap ? snap_m[h_addr[7:0]] :
                is_coef ? coef_m[h_addr[6:0]] :
                (is_ctrl && h_addr != A_ONESHOT) ? ctrl_r[h_addr[3:0]] :
                ZERO16;

  // Control word follows the bus for as long as the write lasts
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < NCTRL; i++) begin
        ctrl_r[i] <= ZERO16;
      end
    end else if (wr_act && is_ctrl && h_addr != A_ONESHOT) begin
      ctrl_r[h_addr[3:0]] <= h_data;
    end
  end

  always_ff @(posedge clk) begin
    if (wr_act && is_coef) begin
      coef_m[h_addr[6:0]] <= h_data;
    end
    if (wr_act && is_snap) begin
      snap_m[h_addr[7:0]] <= h_data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_prev_r        <= 1'b0;
      one_shot_pulse_n <= 1'b1;
      host_data_out    <= ZERO16;
      host_data_oe_n   <= 1'b1;
    end else begin
      wr_prev_r        <= wr_act;
      one_shot_pulse_n <= ~(wr_act & ~wr_prev_r & (h_addr == A_ONESHOT));
      host_data_out    <= rd_act ? rd_w : ZERO16;
      host_data_oe_n   <= ~rd_act;
    end
  end

  // ----------------------------------------
  // Control counter and sync output
  // ----------------------------------------
  logic [CNTW-1:0] cnt_r;
  logic [CNTW-1:0] reload_w;
  logic            resync;
  logic [1:0]      so_sel;

  assign reload_w = {ctrl_r[A_CNT[3:0]], CNT_LOW};
  assign resync   = sync_ev & ~ctrl_r[A_SNAPC[3:0]][F_SSOFF];
  assign so_sel   = ctrl_r[A_OUT[3:0]][F_SOSEL+1:F_SOSEL];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_r            <= CNT_ZERO;
      terminal_count_n <= 1'b1;
      sync_out_n       <= 1'b1;
      count_lsb_out    <= '0;
    end else begin
      cnt_r            <= (resync || cnt_r == CNT_ZERO) ? reload_w : cnt_r - CNT_ONE;
      terminal_count_n <= cnt_r != CNT_ZERO;
      count_lsb_out    <= cnt_r[2:0];
      sync_out_n       <= so_sel == M_0 ? si_d_r[SI_DLY-1] :
                          so_sel == M_1 ? one_shot_pulse_n :
                          so_sel == M_2 ? terminal_count_n : 1'b1;
    end
  end

  // ----------------------------------------
  // Sample FIFO, drained at path A's sample rate
  // ----------------------------------------
  logic [2*SW-1:0] fifo_q;
  logic            fifo_v;
  logic            upd_w [2];

  // Held rates pop less often, so a steady source fills and stalls
  ffehp_fifo #(.W(2*SW), .D(FIFO_DEP)) u_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (samp_valid),
    .in_ready  (samp_ready),
    .in_data   ({samp_b_in, samp_a_in}),
    .out_valid (fifo_v),
    .out_ready (upd_w[0]),
    .out_data  (fifo_q)
  );

  // ----------------------------------------
  // Two filter paths
  // ----------------------------------------
  logic [SW-1:0] dout_w [2];
  logic [SW-1:0] fb_r   [2];
  logic [31:0]   sum_r  [2];
  logic [1:0]    csel_r [2];
  logic [CW-1:0] cf_r   [2];
  logic [31:0]   sum_in [2];
  logic          casc;

  assign casc      = ctrl_r[A_CASC[3:0]][F_CASC];
  assign sum_in[0] = sum_a_in;
  assign sum_in[1] = sum_b_in;

  for (genvar p = 0; p < 2; p++) begin : g_path
    logic [DW-1:0] cfg;
    logic [1:0]    isel, hold, dly, neg, sym, csm, csv, csel_w;
    logic [SW-1:0] sel_w, dly_w, hold_r, neg_r, rin_w;
    logic [SW-1:0] d_r   [3];
    logic [SW-1:0] fwd_r [NCELL];
    logic [SW-1:0] rev_r [NCELL];
    logic          par_r;
    logic          neg_on;

    assign cfg  = ctrl_r[p*(A_BPATH0)];
    assign isel = cfg[F_ISEL+1:F_ISEL];
    assign hold = cfg[F_HOLD+1:F_HOLD];
    assign dly  = cfg[F_DLY+1:F_DLY];
    assign neg  = cfg[F_NEG+1:F_NEG];
    assign sym  = cfg[F_SYM+1:F_SYM];
    assign csm  = cfg[F_CSM+1:F_CSM];
    assign csv  = cfg[F_CSV+1:F_CSV];
    assign sel_w = isel == M_0 ? fifo_q[SW-1:0] :
                   isel == M_1 ? fifo_q[2*SW-1:SW] : cnt_r[SW-1:0];
    assign upd_w[p] = hold == M_1 ? ~cnt_r[0] :
                      hold == M_2 ? cnt_r[1:0] == M_0 : 1'b1;
    assign dly_w = dly == M_1 ? d_r[0] : dly == M_2 ? d_r[2] : hold_r;
    assign neg_on = neg == M_1 | (neg == M_2 & ~par_r) | (neg == M_3 & par_r);
    assign csel_w = csm == M_1 ? {csv[1], cnt_r[0]} :
                    csm == M_2 ? cnt_r[1:0] : csv;
    assign dout_w[p] = fwd_r[NCELL-1];
    // Path A's reverse chain is fed by path B's feedback in cascade
    assign rin_w = (casc && p == 0) ? fb_r[1] : fb_r[p];

    always_ff @(posedge clk) begin
      if (sys_rst) begin
        hold_r    <= '0;
        par_r     <= 1'b0;
        neg_r     <= '0;
        fb_r[p]   <= '0;
        sum_r[p]  <= '0;
        csel_r[p] <= M_0;
        cf_r[p]   <= '0;
        for (int i = 0; i < 3; i++) begin
          d_r[i] <= '0;
        end
        for (int i = 0; i < NCELL; i++) begin
          fwd_r[i] <= '0;
          rev_r[i] <= '0;
        end
      end else begin
        if (upd_w[p]) begin
          hold_r <= sel_w;
          par_r  <= ~par_r;
        end
        d_r[0] <= hold_r;
        d_r[1] <= d_r[0];
        d_r[2] <= d_r[1];
        neg_r  <= neg_on ? SW'(-dly_w) : dly_w;
        fwd_r[0] <= (casc && p == 1) ? dout_w[0] : neg_r;
        for (int i = 1; i < NCELL; i++) begin
          fwd_r[i]   <= fwd_r[i-1];
          rev_r[i-1] <= rev_r[i];
        end
        rev_r[NCELL-1] <= rin_w;
        fb_r[p] <= sym == M_0 ? '0 : sym == M_2 ? SW'(-dout_w[p]) : dout_w[p];
        sum_r[p] <= (casc && p == 1) ? sum_r[0] : sum_in[p];
        csel_r[p] <= csel_w;
        cf_r[p] <= coef_m[{1'(p), 4'h0, csel_w}][CW-1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    data_a_out <= dout_w[0];
    data_b_out <= dout_w[1];
    fb_a_out   <= fb_r[0];
    fb_b_out   <= fb_r[1];
    sum_a_out  <= sum_r[0];
    sum_b_out  <= sum_r[1];
    csel_a_out <= csel_r[0];
    csel_b_out <= csel_r[1];
    coef_a_out <= cf_r[0];
    coef_b_out <= cf_r[1];
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_os;
    @(posedge clk) disable iff (sys_rst)
    wr_act && !wr_prev_r && h_addr == A_ONESHOT |=> !one_shot_pulse_n ##1 one_shot_pulse_n;
  endproperty
  a_os: assert property (p_os) else $error("one-shot pulse wrong");

  property p_tc;
    @(posedge clk) disable iff (sys_rst)
    cnt_r == CNT_ZERO |=> !terminal_count_n;
  endproperty
  a_tc: assert property (p_tc) else $error("terminal strobe missing");

  property p_reload;
    @(posedge clk) disable iff (sys_rst)
    cnt_r == CNT_ZERO ##1 !$past(resync) |-> cnt_r == $past(reload_w);
  endproperty
  a_reload: assert property (p_reload) else $error("counter reload wrong");

  property p_resync;
    @(posedge clk) disable iff (sys_rst)
    resync |=> cnt_r == $past(reload_w);
  endproperty
  a_resync: assert property (p_resync) else $error("sync reload missed");

  property p_oe;
    @(posedge clk) disable iff (sys_rst)
    !host_data_oe_n |-> $past(rd_act) && $past(h_we_n);
  endproperty
  a_oe: assert property (p_oe) else $error("bus driven outside read");

  property p_unmapped;
    @(posedge clk) disable iff (sys_rst)
    rd_act && h_addr > A_LASTC && h_addr < A_COEF |=> host_data_out == ZERO16;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  property p_wr;
    @(posedge clk) disable iff (sys_rst)
    wr_act && h_addr == A_CNT |=> ctrl_r[A_CNT[3:0]] == $past(h_data);
  endproperty
  a_wr: assert property (p_wr) else $error("control write lost");

  property p_so;
    @(posedge clk) disable iff (sys_rst)
    so_sel == M_2 && $stable(so_sel) |-> sync_out_n == $past(terminal_count_n);
  endproperty
  a_so: assert property (p_so) else $error("sync output source wrong");

  property p_casc;
    @(posedge clk) disable iff (sys_rst)
    casc |=> sum_r[1] == $past(sum_r[0]);
  endproperty
  a_casc: assert property (p_casc) else $error("cascade sum not chained");

  property p_fb_off;
    @(posedge clk) disable iff (sys_rst)
    g_path[0].sym == M_0 |=> fb_r[0] == '0;
  endproperty
  a_fb_off: assert property (p_fb_off) else $error("feedback not cleared");

  property p_pop;
    @(posedge clk) disable iff (sys_rst)
    fifo_v && upd_w[0] && g_path[0].isel == M_0 |=> g_path[0].hold_r == $past(fifo_q[SW-1:0]);
  endproperty
  a_pop: assert property (p_pop) else $error("held sample wrong");
endmodule

/* File: sim/ffehp_host_model.sv */
// Purpose: Host processor model for the asynchronous register port
// Assumes: Pins move only just after a rising clock edge
// Notes:   No ready exists, so all waits are fixed counts
`timescale 1ns/1ps
module ffehp_host_model
  import ffehp_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rw_mode,
  input  wire logic [DW-1:0] host_data_out,
  input  wire logic          host_data_oe_n,
  output logic [AW-1:0]      host_addr,
  output logic [DW-1:0]      host_data_in,
  output logic               chip_enable_n,
  output logic               write_strobe_n,
  output logic               read_strobe_n
);
  logic          drv_r = 1'b0;
  logic          re_r  = 1'b1;
  logic [DW-1:0] val_r = 16'h0000;
  // Released bus shows the inverse, so stale data cannot pass
  assign host_data_in  = drv_r ? val_r : (host_data_oe_n ? ~val_r : host_data_out);
  assign read_strobe_n = rw_mode ? 1'b0 : re_r;
  initial begin
    host_addr      = 9'h000;
    chip_enable_n  = 1'b1;
    write_strobe_n = 1'b1;
  end
  // ----------------------------------------
  // Bus cycles
  // ----------------------------------------
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk);
    host_addr <= a;
    val_r     <= d;
    drv_r     <= 1'b1;
    @(posedge clk);
    if (rw_mode) write_strobe_n <= 1'b0;
    else chip_enable_n <= 1'b0;
    @(posedge clk);
    if (rw_mode) chip_enable_n <= 1'b0;
    else write_strobe_n <= 1'b0;
    repeat (6) @(posedge clk);
    if (rw_mode) chip_enable_n <= 1'b1;
    else write_strobe_n <= 1'b1;
    @(posedge clk);
    chip_enable_n  <= 1'b1;
    write_strobe_n <= 1'b1;
    // Synchronizer still samples data after strobes rise
    repeat (5) @(posedge clk);
    drv_r <= 1'b0;
  endtask
  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d, output logic oe);
    @(posedge clk);
    host_addr <= a;
    @(posedge clk);
    chip_enable_n <= 1'b0;
    @(posedge clk);
    re_r <= 1'b0;
    repeat (7) @(posedge clk);
    d  = host_data_out;
    oe = host_data_oe_n;
    re_r          <= 1'b1;
    chip_enable_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
endmodule

/* File: sim/ffehp_tb_top.sv */
// Purpose: Self-checking bench for the FIR front end and host port
// Assumes: Host model drives the register port with fixed waits
// Notes:   Sum chain inputs held at fixed words; cell arithmetic lives outside
`timescale 1ns/1ps
module ffehp_tb_top;
  import ffehp_pkg::*;
  logic          clk        = 1'b0;
  logic          sys_rst    = 1'b1;
  logic          rw_mode    = 1'b0;
  logic          sync_in_n  = 1'b1;
  logic          samp_valid = 1'b0;
  logic [SW-1:0] samp_a_in  = 12'h000;
  logic [AW-1:0] host_addr;
  logic [DW-1:0] host_data_in;
  logic [DW-1:0] host_data_out;
  logic          host_data_oe_n;
  logic          chip_enable_n;
  logic          write_strobe_n;
  logic          read_strobe_n;
  logic          sync_out_n;
  logic          terminal_count_n;
  logic          one_shot_pulse_n;
  logic [2:0]    count_lsb_out;
  logic          samp_ready;
  logic [31:0]   sum_a_in   = 32'h1234_5678;
  logic [31:0]   sum_b_in   = 32'h9abc_def0;
  logic [31:0]   sum_a_out;
  logic [31:0]   sum_b_out;
  logic [SW-1:0] data_a_out;
  logic [SW-1:0] data_b_out;
  logic [SW-1:0] fb_a_out;
  logic [SW-1:0] fb_b_out;
  logic [1:0]    csel_a_out;
  logic [1:0]    csel_b_out;
  logic [CW-1:0] coef_a_out;
  logic [CW-1:0] coef_b_out;
  int            n_fail  = 0;
  int            n_tests = 0;
  always #20 clk = ~clk;
  ffehp_top u_ffehp_top (
    .clk(clk), .sys_rst(sys_rst), .host_addr(host_addr), .host_data_in(host_data_in),
    .host_data_out(host_data_out), .host_data_oe_n(host_data_oe_n),
    .chip_enable_n(chip_enable_n), .write_strobe_n(write_strobe_n),
    .read_strobe_n(read_strobe_n), .sync_in_n(sync_in_n), .sync_out_n(sync_out_n),
    .terminal_count_n(terminal_count_n), .one_shot_pulse_n(one_shot_pulse_n),
    .count_lsb_out(count_lsb_out), .samp_a_in(samp_a_in), .samp_b_in(~samp_a_in),
    .samp_valid(samp_valid), .samp_ready(samp_ready), .sum_a_in(sum_a_in),
    .sum_b_in(sum_b_in), .sum_a_out(sum_a_out), .sum_b_out(sum_b_out),
    .data_a_out(data_a_out), .data_b_out(data_b_out), .fb_a_out(fb_a_out),
    .fb_b_out(fb_b_out), .csel_a_out(csel_a_out), .csel_b_out(csel_b_out),
    .coef_a_out(coef_a_out), .coef_b_out(coef_b_out)
  );
  ffehp_host_model u_ffehp_host_model (
    .clk(clk), .rw_mode(rw_mode), .host_data_out(host_data_out),
    .host_data_oe_n(host_data_oe_n), .host_addr(host_addr), .host_data_in(host_data_in),
    .chip_enable_n(chip_enable_n), .write_strobe_n(write_strobe_n),
    .read_strobe_n(read_strobe_n)
  );
  // ----------------------------------------
  // Compare and report
  // ----------------------------------------
  task automatic chk_word(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t word got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_count(input int got, input int exp);
    n_tests++;
    if (got != exp) begin
      n_fail++;
      $display("[ERR] %0t count got %0d exp %0d", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wait_tc;
    int i;
    for (i = 0; i < 2000; i++) begin
      @(posedge clk);
      if (terminal_count_n === 1'b0) return;
    end
    n_fail++;
    summarize();
  endtask
  task automatic wr_rd(input logic [AW-1:0] a, input logic [DW-1:0] v, input logic [DW-1:0] e);
    logic [DW-1:0] d;
    logic          oe;
    u_ffehp_host_model.wr(a, v);
    u_ffehp_host_model.rd(a, d, oe);
    chk_word(d, e);
    chk_word({15'h0000, oe}, 16'h0000);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    logic [DW-1:0] d;
    logic          oe;
    wr_rd(A_BPATH0, 16'h1234, 16'h1234);
    wr_rd(A_LASTC, 16'hbeef, 16'hbeef);
    wr_rd(A_COEF, 16'h5a5a, 16'h5a5a);
    wr_rd(9'h0ff, 16'hc3c3, 16'hc3c3);
    wr_rd(9'h00d, 16'hffff, 16'h0000);
    wr_rd(9'h07f, 16'hffff, 16'h0000);
    u_ffehp_host_model.rd(A_ONESHOT, d, oe);
    chk_word(d, 16'h0000);
    u_ffehp_host_model.rd(A_SNAP, d, oe);
    chk_word({15'h0000, oe}, 16'h0000);
    chk_word({15'h0000, host_data_oe_n}, 16'h0001);
  endtask
  task automatic t_rw;
    rw_mode <= 1'b1;
    repeat (6) @(posedge clk);
    wr_rd(A_CASC, 16'h0000, 16'h0000);
    wr_rd(A_LASTC, 16'h00a5, 16'h00a5);
    rw_mode <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  task automatic t_oneshot;
    int np = 0;
    int ns = 0;
    u_ffehp_host_model.wr(A_OUT, 16'h0001);
    fork
      u_ffehp_host_model.wr(A_ONESHOT, 16'h00ff);
      repeat (30) begin
        @(posedge clk);
        if (one_shot_pulse_n === 1'b0) np++;
        if (sync_out_n === 1'b0) ns++;
      end
    join
    chk_count(np, 1);
    chk_count(ns, 1);
  endtask
  task automatic t_period;
    int         v;
    int         n;
    int         ns;
    logic [2:0] prev;
    u_ffehp_host_model.wr(A_SNAPC, 16'h0001);
    u_ffehp_host_model.wr(A_OUT, 16'h0002);
    for (v = 0; v < 4; v += 3) begin
      u_ffehp_host_model.wr(A_CNT, 16'(v));
      wait_tc();
      wait_tc();
      n = 0;
      ns = 0;
      prev = count_lsb_out;
      while (n < 2000) begin
        @(posedge clk);
        n++;
        chk_word({13'h0000, count_lsb_out}, {13'h0000, prev - 3'h1});
        prev = count_lsb_out;
        if (sync_out_n === 1'b0) ns++;
        if (terminal_count_n === 1'b0) break;
      end
      chk_count(n, 16 * (v + 1));
      chk_count(ns, 1);
    end
  endtask
  task automatic sync_meas(output int t, output int lo);
    t = 0;
    lo = 0;
    sync_in_n <= 1'b0;
    while (t < 300) begin
      @(posedge clk);
      t++;
      if (t == 3) sync_in_n <= 1'b1;
      if (sync_out_n === 1'b0) lo++;
      if (terminal_count_n === 1'b0 && t > 8) break;
    end
  endtask
  task automatic t_sync;
    int t1;
    int t2;
    int l1;
    int l2;
    u_ffehp_host_model.wr(A_SNAPC, 16'h0000);
    u_ffehp_host_model.wr(A_OUT, 16'h0000);
    wait_tc();
    sync_meas(t1, l1);
    wait_tc();
    // Different phase: only a real resync gives the same distance
    repeat (20) @(posedge clk);
    sync_meas(t2, l2);
    chk_count(t2, t1);
    chk_count(int'(l1 > 0), 1);
  endtask
  task automatic t_fifo;
    int i;
    u_ffehp_host_model.wr(9'h000, 16'h0008);
    samp_valid <= 1'b1;
    for (i = 0; i < 100 && samp_ready !== 1'b0; i++) begin
      @(posedge clk);
      samp_a_in <= samp_a_in + 12'h001;
    end
    chk_count(int'(i >= 16 && i < 100), 1);
    samp_valid <= 1'b0;
    repeat (80) @(posedge clk);
    chk_word({15'h0000, samp_ready}, 16'h0001);
  endtask
  task automatic t_path;
    samp_a_in  <= 12'h123;
    samp_valid <= 1'b1;
    u_ffehp_host_model.wr(9'h082, 16'hffff);
    u_ffehp_host_model.wr(9'h0c1, 16'hc123);
    // A: port A, negate all, even symmetry, coefficient 2
    u_ffehp_host_model.wr(9'h000, 16'h2140);
    // B: port B, anti-symmetric, coefficient 1
    u_ffehp_host_model.wr(A_BPATH0, 16'h1201);
    repeat (40) @(posedge clk);
    chk_word({4'h0, data_a_out}, 16'h0edd);
    chk_word({4'h0, fb_a_out}, 16'h0edd);
    chk_word({4'h0, data_b_out}, 16'h0edc);
    chk_word({4'h0, fb_b_out}, 16'h0124);
    chk_word({14'h0000, csel_a_out}, 16'h0002);
    chk_word({14'h0000, csel_b_out}, 16'h0001);
    chk_word({2'h0, coef_a_out}, 16'h3fff);
    chk_word({2'h0, coef_b_out}, 16'h0123);
    chk_word(sum_a_out[31:16], 16'h1234);
    chk_word(sum_b_out[15:0], 16'hdef0);
    u_ffehp_host_model.wr(A_CASC, 16'h0001);
    repeat (40) @(posedge clk);
    chk_word({4'h0, data_b_out}, 16'h0edd);
    chk_word({4'h0, fb_b_out}, 16'h0123);
    chk_word(sum_b_out[15:0], 16'h5678);
    samp_valid <= 1'b0;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    chk_word({15'h0000, host_data_oe_n}, 16'h0001);
    t_regs();
    t_rw();
    t_oneshot();
    t_period();
    t_sync();
    t_fifo();
    t_path();
    summarize();
  end
endmodule
